// File: inc/zpc_consts.svh
// constants of the zero-point calibration command interpreter
`ifndef ZPC_CONSTS_SVH
`define ZPC_CONSTS_SVH
`define ZPC_CH_G 8'h47
`define ZPC_CH_U 8'h55
`define ZPC_CH_LU 8'h75
`define ZPC_CH_X 8'h58
`define ZPC_CH_P 8'h50
`define ZPC_CH_AT 8'h40
`define ZPC_CH_S 8'h53
`define ZPC_CH_LS 8'h73
`define ZPC_CH_SP 8'h20
`define ZPC_CH_CR 8'h0D
`define ZPC_CH_LF 8'h0A
`define ZPC_CH_DOT 8'h2E
`define ZPC_CH_D0 8'h30
`define ZPC_CH_D9 8'h39
`define ZPC_IDX_AZ_HI 16'h0008
`define ZPC_IDX_AZ_LO 16'h0009
`define ZPC_IDX_FA_HI 16'h000A
`define ZPC_IDX_FA_LO 16'h000B
`define ZPC_AZ_REF_RST 16'h0190
`define ZPC_FA_REF_RST 16'h0190
`define ZPC_COMP_RST 16'h2000
`define ZPC_ZERO_RST 16'h0000
`define ZPC_MULT_RST 8'h01
`define ZPC_OFF_CTRL 8'h00
`define ZPC_OFF_ZERO 8'h04
`define ZPC_OFF_REFS 8'h08
`define ZPC_OFF_AZINT 8'h0C
`define ZPC_OFF_STATUS 8'h10
`define ZPC_OFF_COMP 8'h14
`define ZPC_CTRL_SLEEP_BIT 0
`define ZPC_CTRL_MULT_LSB 8
`define ZPC_RESP_OKAY 2'h0
`define ZPC_RESP_SLVERR 2'h2
`endif

// File: inc/zpc_pkg.sv
// types of the zero-point calibration command interpreter
`default_nettype none
package zpc_pkg;
	typedef enum logic [1:0] {
		ST_RECV = 2'b00,
		ST_EXEC = 2'b01,
		ST_SEND = 2'b10
	} zpc_state_e;
	typedef logic [15:0] zpc_word_t;
	typedef logic [19:0] zpc_bcd_t;
endpackage
`default_nettype wire

// File: rtl/zpc_dec5.sv
// binary to five decimal digit converter
`default_nettype none
module zpc_dec5
	import zpc_pkg::*;
(
	input wire logic [15:0] value,
	output logic [19:0] digits
);
	logic [35:0] work;
	always_comb begin
		work = {20'h00000, value};
		// shift-and-add-three, one pass per input bit
		for (int i = 0; i < 16; i++) begin
			for (int d = 0; d < 5; d++) begin
				if (work[16 + 4 * d +: 4] > 4'h4) begin
					work[16 + 4 * d +: 4] = work[16 + 4 * d +: 4] + 4'h3;
				end
			end
			work = {work[34:0], 1'b0};
		end
		digits = work[35:16];
	end
endmodule
`default_nettype wire

// File: rtl/zpc_cmd_interp.sv
// command line interpreter for zero-point, reference, interval and compensation settings
//
// Overview of operation
// - G line rezeroes in air, replies value
// - fresh-air zero uses stored air reference
// - U line zeroes at 0 ppm, replies value
// - u value forced as zero, replies value
// - concentration arguments scaled by multiplier
// - X line zeroes against given concentration
// - auto-zero reference via index 8 high, 9 low
// - air reference via 10/11; reply P index value
// - @ stores initial, regular intervals; echoes line
// - auto-zero off until nonzero intervals given
// - @ with single zero disables auto-zero
// - bare @ reports auto-zero configuration
// - S value stored as compensation, default 8192
// - S reply is stored value, five digits
// - s reports compensation without changing it
// - sleep mode ignores zero-altering commands
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "zpc_consts.svh"
`default_nettype none
module zpc_cmd_interp
	import zpc_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	output logic rxReady,
	output logic [7:0] txData,
	output logic txValid,
	input wire logic txReady,
	input wire logic [15:0] sensorSignal,
	output logic [15:0] zeroPoint,
	output logic [15:0] compFactor,
	output logic autoZeroEnable,
	output logic [15:0] initialInterval,
	output logic [15:0] regularInterval
);
	localparam int PW = $clog2(DEPTH + 2) + 1;

	zpc_state_e state_reg;
	logic [7:0] lineBuf [DEPTH];
	logic [PW-1:0] lineLen_reg;
	logic [7:0] cmd_reg;
	logic [1:0] argCount_reg;
	zpc_word_t arg0_reg;
	zpc_word_t arg1_reg;
	logic sawCr_reg;
	logic bad_reg;
	logic rxTake;
	logic lineEnd;
	logic lineDone;
	logic isDigit;

	logic [31:0] ctrl_reg;
	logic sleepMode;
	logic [7:0] mult;
	zpc_word_t zero_reg;
	zpc_word_t azRef_reg;
	zpc_word_t faRef_reg;
	zpc_word_t initInt_reg;
	zpc_word_t regInt_reg;
	logic azEn_reg;
	zpc_word_t comp_reg;

	logic act;
	logic doZero;
	zpc_word_t zero_next;
	logic doAzRef;
	logic doFaRef;
	zpc_word_t ref_next;
	logic doInt;
	zpc_word_t initInt_next;
	zpc_word_t regInt_next;
	logic doComp;
	logic [7:0] letter_next;
	logic [1:0] nf_next;
	logic echo_next;
	zpc_word_t val1_next;
	zpc_word_t val2_next;
	logic [23:0] scaledArg;
	logic [23:0] scaledFa;

	logic [7:0] letter_reg;
	logic [1:0] nf_reg;
	logic echo_reg;
	zpc_word_t val1_reg;
	zpc_word_t val2_reg;
	logic [19:0] bcd1;
	logic [19:0] bcd2;
	logic [PW-1:0] pos_reg;
	logic [PW-1:0] bodyLen;
	logic [7:0] byteOut;
	logic [7:0] txData_reg;
	logic txValid_reg;
	logic txLoad;

	logic axiWr;
	logic axiRd;
	logic [1:0] bresp_reg;
	logic bvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic rvalid_reg;

	assign sleepMode = ctrl_reg[`ZPC_CTRL_SLEEP_BIT];
	assign mult = ctrl_reg[`ZPC_CTRL_MULT_LSB +: 8];
	assign rxReady = (state_reg == ST_RECV);
	assign rxTake = rxValid && rxReady;
	assign isDigit = (rxData >= `ZPC_CH_D0) && (rxData <= `ZPC_CH_D9);
	assign lineEnd = rxTake && (rxData == `ZPC_CH_LF);
	// parser state lives until the line is refused or its reply has left
	assign lineDone = ((state_reg == ST_EXEC) && !act)
		|| ((state_reg == ST_SEND) && (pos_reg > bodyLen + PW'(1)) && (!txValid_reg || txReady));

	// line parser; a byte is stored only while the buffer has room
	always_ff @(posedge mclk) begin
		if (srst || lineDone || lineEnd) begin
			if (srst || lineDone || !sawCr_reg || bad_reg || lineLen_reg == '0) begin
				lineLen_reg <= '0;
				argCount_reg <= 2'h0;
				sawCr_reg <= 1'b0;
				bad_reg <= 1'b0;
			end
			if (srst) begin
				cmd_reg <= 8'h00;
				arg0_reg <= 16'h0000;
				arg1_reg <= 16'h0000;
			end
		end else if (rxTake) begin
			if (rxData == `ZPC_CH_CR) begin
				if (sawCr_reg) begin
					bad_reg <= 1'b1;
				end
				sawCr_reg <= 1'b1;
			end else begin
				if (sawCr_reg || lineLen_reg >= PW'(DEPTH)) begin
					bad_reg <= 1'b1;
				end else begin
					lineBuf[lineLen_reg[$clog2(DEPTH)-1:0]] <= rxData;
					lineLen_reg <= lineLen_reg + PW'(1);
				end
				if (lineLen_reg == '0) begin
					cmd_reg <= rxData;
				end else if (rxData == `ZPC_CH_SP) begin
					if (argCount_reg == 2'h2) begin
						bad_reg <= 1'b1;
					end else begin
						argCount_reg <= argCount_reg + 2'h1;
					end
					if (argCount_reg == 2'h0) begin
						arg0_reg <= 16'h0000;
					end else begin
						arg1_reg <= 16'h0000;
					end
				end else if (isDigit && argCount_reg != 2'h0) begin
					if (argCount_reg == 2'h1) begin
						arg0_reg <= 16'((arg0_reg << 3) + (arg0_reg << 1) + (rxData - `ZPC_CH_D0));
					end else begin
						arg1_reg <= 16'((arg1_reg << 3) + (arg1_reg << 1) + (rxData - `ZPC_CH_D0));
					end
				end else if (!(rxData == `ZPC_CH_DOT && cmd_reg == `ZPC_CH_AT)) begin
					// the decimal point is skipped in @ lines, so digits run on and 1.0 reads as 10
					bad_reg <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_RECV;
		end else begin
			case (state_reg)
				ST_RECV: begin
					// an empty line would replay the previous command letter
					if (lineEnd && sawCr_reg && !bad_reg && lineLen_reg != '0) begin
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					state_reg <= act ? ST_SEND : ST_RECV;
				end
				ST_SEND: begin
					if (pos_reg > bodyLen + PW'(1) && (!txValid_reg || txReady)) begin
						state_reg <= ST_RECV;
					end
				end
				default: state_reg <= ST_RECV;
			endcase
		end
	end

	assign scaledArg = arg0_reg * mult;
	assign scaledFa = faRef_reg * mult;

	// command decode, evaluated in the execute cycle only
	always_comb begin
		act = 1'b0;
		doZero = 1'b0;
		zero_next = zero_reg;
		doAzRef = 1'b0;
		doFaRef = 1'b0;
		ref_next = 16'h0000;
		doInt = 1'b0;
		initInt_next = 16'h0000;
		regInt_next = 16'h0000;
		doComp = 1'b0;
		letter_next = cmd_reg;
		nf_next = 2'h1;
		echo_next = 1'b0;
		val1_next = 16'h0000;
		val2_next = 16'h0000;
		case (cmd_reg)
			`ZPC_CH_G: begin
				act = (argCount_reg == 2'h0) && !sleepMode;
				doZero = act;
				zero_next = 16'(sensorSignal + scaledFa[15:0]);
				val1_next = zero_next;
			end
			`ZPC_CH_U: begin
				act = (argCount_reg == 2'h0) && !sleepMode;
				doZero = act;
				zero_next = sensorSignal;
				val1_next = zero_next;
			end
			`ZPC_CH_LU: begin
				act = (argCount_reg == 2'h1) && !sleepMode;
				doZero = act;
				zero_next = scaledArg[15:0];
				val1_next = arg0_reg;
			end
			`ZPC_CH_X: begin
				act = (argCount_reg == 2'h1) && !sleepMode;
				doZero = act;
				zero_next = 16'(sensorSignal + scaledArg[15:0]);
				val1_next = zero_next;
			end
			`ZPC_CH_P: begin
				act = (argCount_reg == 2'h2) && !sleepMode && (arg0_reg >= `ZPC_IDX_AZ_HI)
					&& (arg0_reg <= `ZPC_IDX_FA_LO);
				doAzRef = act && (arg0_reg <= `ZPC_IDX_AZ_LO);
				doFaRef = act && (arg0_reg >= `ZPC_IDX_FA_HI);
				if (arg0_reg == `ZPC_IDX_AZ_HI) begin
					ref_next = {arg1_reg[7:0], azRef_reg[7:0]};
				end else if (arg0_reg == `ZPC_IDX_AZ_LO) begin
					ref_next = {azRef_reg[15:8], arg1_reg[7:0]};
				end else if (arg0_reg == `ZPC_IDX_FA_HI) begin
					ref_next = {arg1_reg[7:0], faRef_reg[7:0]};
				end else begin
					ref_next = {faRef_reg[15:8], arg1_reg[7:0]};
				end
				nf_next = 2'h2;
				val1_next = arg0_reg;
				val2_next = arg1_reg;
			end
			`ZPC_CH_AT: begin
				if (argCount_reg == 2'h0) begin
					act = 1'b1;
					nf_next = 2'h2;
					val1_next = initInt_reg;
					val2_next = regInt_reg;
				end else if (argCount_reg == 2'h1) begin
					act = (arg0_reg == 16'h0000) && !sleepMode;
					doInt = act;
					echo_next = 1'b1;
				end else begin
					act = !sleepMode;
					doInt = act;
					initInt_next = arg0_reg;
					regInt_next = arg1_reg;
					echo_next = 1'b1;
				end
			end
			`ZPC_CH_S: begin
				act = (argCount_reg == 2'h1);
				doComp = act;
				val1_next = arg0_reg;
			end
			`ZPC_CH_LS: begin
				act = (argCount_reg == 2'h0);
				val1_next = comp_reg;
			end
			default: act = 1'b0;
		endcase
	end

	// settings move only in the execute cycle
	always_ff @(posedge mclk) begin
		if (srst) begin
			zero_reg <= `ZPC_ZERO_RST;
			azRef_reg <= `ZPC_AZ_REF_RST;
			faRef_reg <= `ZPC_FA_REF_RST;
			initInt_reg <= 16'h0000;
			regInt_reg <= 16'h0000;
			azEn_reg <= 1'b0;
			comp_reg <= `ZPC_COMP_RST;
		end else if (state_reg == ST_EXEC) begin
			if (doZero) begin
				zero_reg <= zero_next;
			end
			if (doAzRef) begin
				azRef_reg <= ref_next;
			end
			if (doFaRef) begin
				faRef_reg <= ref_next;
			end
			if (doInt) begin
				initInt_reg <= initInt_next;
				regInt_reg <= regInt_next;
				azEn_reg <= (initInt_next != 16'h0000) || (regInt_next != 16'h0000);
			end
			if (doComp) begin
				comp_reg <= arg0_reg;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			letter_reg <= 8'h00;
			nf_reg <= 2'h0;
			echo_reg <= 1'b0;
			val1_reg <= 16'h0000;
			val2_reg <= 16'h0000;
		end else if (state_reg == ST_EXEC) begin
			letter_reg <= letter_next;
			nf_reg <= nf_next;
			echo_reg <= echo_next;
			val1_reg <= val1_next;
			val2_reg <= val2_next;
		end
	end

	zpc_dec5 u_dec1 (
		.value(val1_reg),
		.digits(bcd1)
	);

	zpc_dec5 u_dec2 (
		.value(val2_reg),
		.digits(bcd2)
	);

	assign bodyLen = echo_reg ? lineLen_reg : (nf_reg == 2'h2) ? PW'(13) : PW'(7);

	// reply byte at the current position: letter, fields, then CR LF
	always_comb begin
		byteOut = `ZPC_CH_SP;
		if (pos_reg == bodyLen) begin
			byteOut = `ZPC_CH_CR;
		end else if (pos_reg == bodyLen + PW'(1)) begin
			byteOut = `ZPC_CH_LF;
		end else if (echo_reg) begin
			byteOut = lineBuf[pos_reg[$clog2(DEPTH)-1:0]];
		end else begin
			case (pos_reg)
				PW'(0): byteOut = letter_reg;
				PW'(2): byteOut = {4'h3, bcd1[19:16]};
				PW'(3): byteOut = {4'h3, bcd1[15:12]};
				PW'(4): byteOut = {4'h3, bcd1[11:8]};
				PW'(5): byteOut = {4'h3, bcd1[7:4]};
				PW'(6): byteOut = {4'h3, bcd1[3:0]};
				PW'(8): byteOut = {4'h3, bcd2[19:16]};
				PW'(9): byteOut = {4'h3, bcd2[15:12]};
				PW'(10): byteOut = {4'h3, bcd2[11:8]};
				PW'(11): byteOut = {4'h3, bcd2[7:4]};
				PW'(12): byteOut = {4'h3, bcd2[3:0]};
				default: byteOut = `ZPC_CH_SP;
			endcase
		end
	end

	assign txLoad = (state_reg == ST_SEND) && (!txValid_reg || txReady);

	always_ff @(posedge mclk) begin
		if (srst || state_reg != ST_SEND) begin
			pos_reg <= '0;
			txValid_reg <= 1'b0;
			txData_reg <= 8'h00;
		end else if (txLoad) begin
			// the line buffer stays intact until the reply has left
			if (pos_reg <= bodyLen + PW'(1)) begin
				txData_reg <= byteOut;
				txValid_reg <= 1'b1;
				pos_reg <= pos_reg + PW'(1);
			end else begin
				txValid_reg <= 1'b0;
			end
		end
	end

	assign txData = txData_reg;
	assign txValid = txValid_reg;

	// register slave; address and data are taken together in one beat
	assign axiWr = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign axiRd = s_axi_arvalid && !rvalid_reg;
	assign s_axi_awready = axiWr;
	assign s_axi_wready = axiWr;
	assign s_axi_arready = axiRd;

	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_reg <= {16'h0000, `ZPC_MULT_RST, 8'h00};
			bvalid_reg <= 1'b0;
			bresp_reg <= `ZPC_RESP_OKAY;
		end else if (axiWr) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= `ZPC_RESP_OKAY;
			case (s_axi_awaddr[7:0])
				`ZPC_OFF_CTRL: begin
					if (s_axi_wstrb[0]) begin
						ctrl_reg[7:0] <= {7'h00, s_axi_wdata[0]};
					end
					if (s_axi_wstrb[1]) begin
						ctrl_reg[15:8] <= s_axi_wdata[15:8];
					end
				end
				`ZPC_OFF_ZERO, `ZPC_OFF_REFS, `ZPC_OFF_AZINT, `ZPC_OFF_STATUS,
				`ZPC_OFF_COMP: bresp_reg <= `ZPC_RESP_OKAY;
				default: bresp_reg <= `ZPC_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `ZPC_RESP_OKAY;
		end else if (axiRd) begin
			rvalid_reg <= 1'b1;
			rresp_reg <= `ZPC_RESP_OKAY;
			case (s_axi_araddr[7:0])
				`ZPC_OFF_CTRL: rdata_reg <= ctrl_reg;
				`ZPC_OFF_ZERO: rdata_reg <= {16'h0000, zero_reg};
				`ZPC_OFF_REFS: rdata_reg <= {faRef_reg, azRef_reg};
				`ZPC_OFF_AZINT: rdata_reg <= {regInt_reg, initInt_reg};
				`ZPC_OFF_STATUS: rdata_reg <= {30'h00000000, state_reg != ST_RECV, azEn_reg};
				`ZPC_OFF_COMP: rdata_reg <= {16'h0000, comp_reg};
				default: begin
					rdata_reg <= 32'h00000000;
					rresp_reg <= `ZPC_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	assign zeroPoint = zero_reg;
	assign compFactor = comp_reg;
	assign autoZeroEnable = azEn_reg;
	assign initialInterval = initInt_reg;
	assign regularInterval = regInt_reg;
endmodule
`default_nettype wire

// File: sim/zpc_cmd_interp_asserts.sv
// port checker for the command interpreter
`default_nettype none
module zpc_cmd_interp_asserts (
	input wire logic mclk,
	input wire logic srst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] rxData,
	input wire logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	input wire logic txReady,
	input wire logic [15:0] zeroPoint,
	input wire logic [15:0] compFactor,
	input wire logic autoZeroEnable,
	input wire logic [15:0] initialInterval,
	input wire logic [15:0] regularInterval
);
	timeunit 1ns;
	timeprecision 1ns;
	logic crPrev;
	logic lineEnd;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (srst);
	// a bare LF is not a line end, so track the byte before it
	assign lineEnd = rxValid && rxReady && rxData == 8'h0A && crPrev;
	always_ff @(posedge mclk) begin
		if (srst)
			crPrev <= 1'b0;
		else if (rxValid && rxReady)
			crPrev <= rxData == 8'h0D;
	end
	a_rx_block: assert property (txValid |-> !rxReady)
		else $error("byte accepted while a reply is out");
	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply byte dropped before taken");
	a_line_answer: assert property (lineEnd |-> ##3 (txValid || rxReady))
		else $error("no reply or ready three cycles after line end");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_w_answer: assert property (s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write data taken without response");
	a_zero_quiet: assert property (!$stable(zeroPoint) |-> !rxReady)
		else $error("zero point moved while receiving");
	a_comp_quiet: assert property (!$stable(compFactor) |-> !rxReady)
		else $error("compensation moved while receiving");
	a_az_link: assert property (autoZeroEnable |-> (initialInterval != 16'h0000 || regularInterval != 16'h0000))
		else $error("auto-zero on with zero intervals");
	cover property (lineEnd ##3 txValid);
	cover property (lineEnd ##3 rxReady);
	cover property ($fell(autoZeroEnable));
endmodule
bind zpc_cmd_interp zpc_cmd_interp_asserts i_zpc_cmd_interp_asserts (.*);
`default_nettype wire

// File: sim/zpc_host_model.sv
// host model that sends command lines and gathers replies
`default_nettype none
module zpc_host_model (
	input wire logic mclk,
	input wire logic rxReady,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady,
	input wire logic slow
);
	timeunit 1ns;
	timeprecision 1ns;
	string reply = "";
	initial begin
		rxData = 8'h00;
		rxValid = 1'b0;
		txReady = 1'b1;
	end
	// a stalling host drops ready every other cycle
	always @(posedge mclk) begin
		txReady <= slow ? ~txReady : 1'b1;
		if (txValid && txReady)
			reply = {reply, $sformatf("%c", txData)};
	end
	task automatic sendLine(input string s);
		string t;
		t = {s, "\r\n"};
		reply = "";
		foreach (t[i]) begin
			rxData <= t[i];
			rxValid <= 1'b1;
			@(negedge mclk);
			while (!rxReady) @(negedge mclk);
			@(posedge mclk);
		end
		rxValid <= 1'b0;
		// released line must not keep showing the last byte
		rxData <= ~rxData;
	endtask
	// replies may trail a measurement, so the wait is generous
	task automatic getReply(output string r);
		int n;
		n = 0;
		while (n < 400 && (reply.len() == 0 || reply[reply.len()-1] != 8'h0A)) begin
			@(negedge mclk);
			n++;
		end
		r = reply;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

// File: sim/zpc_cmd_interp_tb.sv
// self-checking bench for the command interpreter
`default_nettype none
module zpc_cmd_interp_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic [15:0] sensorSignal = 16'h1000;
	logic slow = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] rxData, txData;
	logic rxValid, rxReady, txValid, txReady, autoZeroEnable;
	logic [15:0] zeroPoint, compFactor, initialInterval, regularInterval;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	zpc_cmd_interp i_zpc_cmd_interp (.*);
	zpc_host_model i_zpc_host_model (.*);
	always #5 mclk = ~mclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd(input string line, input string exp);
		string r;
		i_zpc_host_model.sendLine(line);
		i_zpc_host_model.getReply(r);
		// line ends shown as underscores to keep each message on one line
		foreach (r[i]) if (r[i] < 8'h20) r[i] = "_";
		if (exp != "") exp = {exp, "__"};
		checks_done++;
		if (r != exp) begin
			num_errors++;
			$display("MISMATCH reply to %s expected %s seen %s", line, exp, r);
		end
	endtask
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		@(negedge mclk);
		while (!s_axi_awready) @(negedge mclk);
		@(posedge mclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		@(negedge mclk);
		while (!s_axi_bvalid) @(negedge mclk);
		chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
		@(posedge mclk);
		s_axi_bready <= 1'b0;
		// one edge apart so a following call never drives bready twice at once
		@(posedge mclk);
	endtask
	task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		@(negedge mclk);
		while (!s_axi_arready) @(negedge mclk);
		@(posedge mclk);
		s_axi_arvalid <= 1'b0;
		@(negedge mclk);
		while (!s_axi_rvalid) @(negedge mclk);
		chk("rdata", ed, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge mclk);
		s_axi_rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			summarize();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		axiRd(8'h00, 32'h0000_0100, 2'h0);
		axiRd(8'h08, 32'h0190_0190, 2'h0);
		axiRd(8'h0C, 32'h0000_0000, 2'h0);
		axiRd(8'h10, 32'h0000_0000, 2'h0);
		axiRd(8'h14, 32'h0000_2000, 2'h0);
		axiRd(8'h20, 32'h0000_0000, 2'h2);
		axiWr(8'h24, 32'h0000_0001, 2'h2);
		$display("test reset and registers done");
		cmd("s", "s 08192");
		cmd("S 123", "S 00123");
		chk("comp", 32'h0000_007B, {16'h0, compFactor});
		cmd("s", "s 00123");
		cmd("U", "U 04096");
		cmd("G", "G 04496");
		cmd("P 10 7", "P 00010 00007");
		cmd("P 11 208", "P 00011 00208");
		cmd("P 8 0", "P 00008 00000");
		cmd("P 9 40", "P 00009 00040");
		axiRd(8'h08, 32'h07D0_0028, 2'h0);
		cmd("G", "G 06096");
		axiWr(8'h00, 32'h0000_0200, 2'h0);
		cmd("G", "G 08096");
		cmd("u 100", "u 00100");
		chk("zero", 32'h0000_00C8, {16'h0, zeroPoint});
		cmd("X 50", "X 04196");
		$display("test zero commands done");
		cmd("@", "@ 00000 00000");
		cmd("@ 1.0 8.0", "@ 1.0 8.0");
		chk("intervals", 32'h000A_0050, {initialInterval, regularInterval});
		chk("azon", 32'h1, {31'h0, autoZeroEnable});
		cmd("@", "@ 00010 00080");
		cmd("@ 0", "@ 0");
		chk("azoff", 32'h0, {31'h0, autoZeroEnable});
		$display("test auto-zero done");
		cmd("Q", "");
		cmd("u 1a", "");
		cmd("U\n", "");
		chk("zero", 32'h0000_1064, {16'h0, zeroPoint});
		axiWr(8'h00, 32'h0000_0201, 2'h0);
		cmd("U", "");
		cmd("u 7", "");
		chk("zero", 32'h0000_1064, {16'h0, zeroPoint});
		slow <= 1'b1;
		cmd("s", "s 00123");
		slow <= 1'b0;
		$display("test refusals and sleep done");
		summarize();
	end
endmodule
`default_nettype wire
